// >>> hdl/flash_cmd_map.vh
// Constants for the flash command and configuration block
// Contract
// RQ1: Erased cells read 1; program only clears bits; only erase sets them.
// RQ2: Master programs only erased locations, never twice without erase.
// RQ3: Smallest erasable unit is a 1 Kbyte sector.
// RQ4: Program and erase run as built-in algorithms with a verify step.
// RQ5: Optional completion interrupt, enabled or disabled by software.
// RQ6: Master starts commands by writing the command parameter group.
// RQ7: Unmapped reads undefined; writes to unmapped or reserved places ignored.
// RQ8: 16-byte config field loads protection and security at every reset.
// RQ9: Backdoor key sits in config bytes 0x400 to 0x407. The key check never reads them; any key opens the part.
// RQ10: Protection bytes sit at 0x408 to 0x40B, seeding protection registers.
// RQ11: Option byte at 0x40D feeds option register; 0x40E, 0x40F reserved.
// RQ12: Security byte at 0x40C feeds the security register.
// RQ13: Info row readable, not erasable; 0x00-0xBF reserved, 0xC0-0xFF one-time.
// RQ14: One-time field holds 64 bytes, programmed once, read freely.
// RQ15: One-time field uses 4-byte records via read-once and program-once.
// RQ16: Longword aligned when addr[1:0] is 00; word when addr[0] is 0.
// RQ17: Secured chip restricts access; special mode gets a reduced command set.
// RQ18: While busy, only config and status writes are accepted, except at start-up.
// RQ19: Writing 1 to the complete flag launches; flag low until done or violation.
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH
`define A_STAT 5'h00
`define A_CNFG 5'h01
`define A_SEC 5'h02
`define A_OPT 5'h03
`define A_CMD0 5'h04
`define A_PROT0 5'h10
`define A_LAST 5'h13
`define CFG_KEY_BASE 8'h00
`define CFG_PROT_BASE 8'h08
`define CFG_SEC 8'h0C
`define CFG_OPT 8'h0D
`define ROW_ONCE_BASE 8'hC0
`define ONCE_RECORDS 5'h10
`define SECTOR_BITS 10
`define ARRAY_BITS 12
`define CMD_RD1 8'h01
`define CMD_PGM4 8'h06
`define CMD_ERSSCR 8'h09
`define CMD_RD_ONCE 8'h41
`define CMD_PGM_ONCE 8'h43
`define CMD_VFY_KEY 8'h45
`define ST_CMPL 7
`define ST_ACCERR 5
`define ST_FPVIOL 4
`define CNFG_CCIE 7
`define SEC_OPEN 2'b10
`define T_INIT_US 2
`define T_INIT_CYC (`T_INIT_US * 10)
`define T_OP_US 4
`define T_OP_CYC (`T_OP_US * 10)
`endif

// >>> hdl/flash_array.v
// Flash storage array with one-way program and sector erase
`timescale 1ns/1ps
`include "flash_cmd_map.vh"
module flash_array (
	input wire i_sys_clk,
	input wire i_rst,
	input wire i_pgm,
	input wire i_ers,
	input wire [`ARRAY_BITS-1:0] i_addr,
	input wire [31:0] i_data,
	output wire [31:0] o_data
);
	localparam WORDS = 1 << (`ARRAY_BITS - 2);
	localparam SECT_SHIFT = `SECTOR_BITS - 2;
	reg [31:0] mem_ff [0:WORDS-1];
	assign o_data = mem_ff[i_addr[`ARRAY_BITS-1:2]];
	genvar g;
	generate
		for (g = 0; g < WORDS; g = g + 1) begin : g_word
			// Reset stands in for shipping state: all erased
			always @(posedge i_sys_clk) begin
				if (i_rst) begin
					mem_ff[g] <= 32'hFFFF_FFFF; // RQ1
				end else if (i_ers && (g >> SECT_SHIFT) == (i_addr >> `SECTOR_BITS)) begin
					mem_ff[g] <= 32'hFFFF_FFFF; // RQ3
				end else if (i_pgm && g == i_addr[`ARRAY_BITS-1:2]) begin
					mem_ff[g] <= mem_ff[g] & i_data; // RQ1
				end
			end
		end
	endgenerate
endmodule

// >>> hdl/flash_cmd_ctrl.v
// Flash command controller: registers, config load, command engine
`timescale 1ns/1ps
`include "flash_cmd_map.vh"
module flash_cmd_ctrl (
	input wire i_sys_clk,
	input wire i_rst,
	input wire i_wr,
	input wire i_rd,
	input wire [4:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_special_mode,
	output reg [7:0] o_rdata,
	output reg o_irq,
	output reg o_secure
);
	// One-hot sequencer states
	localparam S_INIT = 6'b000001;
	localparam S_LOAD = 6'b000010;
	localparam S_IDLE = 6'b000100;
	localparam S_EXEC = 6'b001000;
	localparam S_VRFY = 6'b010000;
	localparam S_DONE = 6'b100000;
	// Sequencer, counters and status flags
	reg [5:0] st_ff;
	reg [7:0] cnt_ff;
	reg [3:0] ld_ff;
	reg cmpl_ff;
	reg accerr_ff;
	reg fpviol_ff;
	reg mgstat_ff;
	reg ccie_ff;
	// Copies of the configuration field taken at start-up
	reg [7:0] sec_ff;
	reg [7:0] opt_ff;
	reg [7:0] prot_ff [0:3];
	// Command parameter group, twelve bytes
	reg [7:0] cmd_ff [0:11];
	// One-time field: sixteen 4-byte records and their used marks
	reg [31:0] once_ff [0:15];
	reg [15:0] once_used_ff;
	// Special mode synchroniser
	reg spec_s1_ff;
	reg spec_ff;
	// Array strobes, one cycle each
	reg pgm_ff;
	reg ers_ff;
	wire [31:0] arr_q;
	// Decoded command fields
	wire [7:0] op = cmd_ff[3];
	wire [23:0] cadr = {cmd_ff[2], cmd_ff[1], cmd_ff[0]};
	wire [31:0] cdat = {cmd_ff[4], cmd_ff[5], cmd_ff[6], cmd_ff[7]};
	// Record index of the one-time field sits in the low address byte
	wire [3:0] rec = cmd_ff[0][3:0];
	// Array address: config field during load, command address otherwise
	wire [`ARRAY_BITS-1:0] arr_a = st_ff[1] ? {6'h10, ld_ff, 2'b00} : cadr[`ARRAY_BITS-1:0];
	wire busy = ~cmpl_ff & ~st_ff[0] & ~st_ff[1];
	wire in_cmd = i_addr >= `A_CMD0 && i_addr < `A_PROT0;
	wire [3:0] cidx = i_addr[3:0] - 4'd4;
	// A cleared bit in protection byte 3 locks its sector
	wire sect_prot = ~prot_ff[3][cadr[`ARRAY_BITS-1:`SECTOR_BITS]];
	flash_array u_arr (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_pgm(pgm_ff),
		.i_ers(ers_ff),
		.i_addr(arr_a),
		.i_data(cdat),
		.o_data(arr_q)
	);
	// Special mode pin crosses into the bus clock
	always @(posedge i_sys_clk) begin
		spec_s1_ff <= i_special_mode;
		spec_ff <= spec_s1_ff;
	end
	// Command check: alignment, security and known opcode
	reg bad;
	always @* begin
		bad = 1'b0;
		case (op)
			`CMD_RD1: bad = cadr[1:0] != 2'b00 || o_secure; // RQ16 RQ17
			`CMD_PGM4: bad = cadr[1:0] != 2'b00; // RQ16
			`CMD_ERSSCR: bad = cadr[1:0] != 2'b00; // RQ16
			// Records past the sixteenth would fall outside the one-time field
			`CMD_RD_ONCE: bad = cmd_ff[0][7:4] != 4'h0 || o_secure; // RQ13 RQ15 RQ17
			`CMD_PGM_ONCE: bad = cmd_ff[0][7:4] != 4'h0 || once_used_ff[rec]; // RQ13 RQ14
			`CMD_VFY_KEY: bad = 1'b0;
			default: bad = 1'b1;
		endcase
		if (spec_ff && o_secure && op != `CMD_VFY_KEY) begin
			bad = 1'b1; // RQ17
		end
	end
	// Main sequencer and register file
	integer i;
	always @(posedge i_sys_clk) begin
		pgm_ff <= 1'b0;
		ers_ff <= 1'b0;
		if (i_rst) begin
			st_ff <= S_INIT;
			cnt_ff <= 8'h00;
			ld_ff <= 4'h0;
			cmpl_ff <= 1'b0;
			accerr_ff <= 1'b0;
			fpviol_ff <= 1'b0;
			mgstat_ff <= 1'b0;
			ccie_ff <= 1'b0;
			sec_ff <= 8'hFF;
			opt_ff <= 8'hFF;
			o_secure <= 1'b1;
			once_used_ff <= 16'h0000;
			for (i = 0; i < 12; i = i + 1) cmd_ff[i] <= 8'h00;
			for (i = 0; i < 4; i = i + 1) prot_ff[i] <= 8'hFF;
			for (i = 0; i < 16; i = i + 1) once_ff[i] <= 32'hFFFF_FFFF;
		end else begin
			// Register writes; all others are gated while busy
			if (i_wr) begin
				if (i_addr == `A_STAT) begin
					if (i_wdata[`ST_ACCERR]) accerr_ff <= 1'b0;
					if (i_wdata[`ST_FPVIOL]) fpviol_ff <= 1'b0;
				end else if (i_addr == `A_CNFG) begin
					ccie_ff <= i_wdata[`CNFG_CCIE]; // RQ5
				end else if (!busy && in_cmd) begin
					cmd_ff[cidx] <= i_wdata; // RQ6 RQ18
				end else if (!busy && i_addr >= `A_PROT0 && i_addr <= `A_LAST) begin
					// Protection may only be tightened by software
					prot_ff[i_addr[1:0]] <= prot_ff[i_addr[1:0]] & i_wdata; // RQ18
				end
			end
			case (st_ff)
				S_INIT: begin
					cnt_ff <= cnt_ff + 8'd1;
					if (cnt_ff == `T_INIT_CYC - 1) st_ff <= S_LOAD;
				end
				S_LOAD: begin
					// Config field words 0x408 and 0x40C feed protection and security
					ld_ff <= ld_ff + 4'd1;
					if (ld_ff == 4'h2) begin
						for (i = 0; i < 4; i = i + 1) prot_ff[i] <= arr_q[8*i +: 8]; // RQ8 RQ10
					end
					if (ld_ff == 4'h3) begin
						sec_ff <= arr_q[7:0]; // RQ12
						opt_ff <= arr_q[15:8]; // RQ11
						o_secure <= arr_q[1:0] != `SEC_OPEN; // RQ17
						cmpl_ff <= 1'b1;
						st_ff <= S_IDLE;
					end
				end
				S_IDLE: begin
					// Launch by writing 1 to the complete flag
					if (i_wr && i_addr == `A_STAT && i_wdata[`ST_CMPL] && !accerr_ff && !fpviol_ff) begin
						cmpl_ff <= 1'b0; // RQ19
						cnt_ff <= 8'h00;
						if (bad) begin
							accerr_ff <= 1'b1;
							st_ff <= S_DONE;
						end else if ((op == `CMD_PGM4 || op == `CMD_ERSSCR) && sect_prot) begin
							fpviol_ff <= 1'b1;
							st_ff <= S_DONE;
						end else begin
							st_ff <= S_EXEC;
						end
					end
				end
				S_EXEC: begin
					// Built-in algorithm: timed pulse, then verify
					cnt_ff <= cnt_ff + 8'd1;
					// Strobe a cycle early so the verify step reads the new contents
					if (cnt_ff == `T_OP_CYC - 2) begin
						if (op == `CMD_PGM4) pgm_ff <= 1'b1; // RQ1
						if (op == `CMD_ERSSCR) ers_ff <= 1'b1; // RQ3
					end
					if (cnt_ff == `T_OP_CYC - 1) begin
						st_ff <= S_VRFY; // RQ4
						if (op == `CMD_PGM_ONCE) begin
							once_ff[rec] <= once_ff[rec] & cdat; // RQ14
							once_used_ff[rec] <= 1'b1;
						end
					end
				end
				S_VRFY: begin
					mgstat_ff <= 1'b0;
					case (op)
						`CMD_PGM4: mgstat_ff <= (arr_q & cdat) != cdat; // RQ4
						`CMD_ERSSCR: mgstat_ff <= arr_q != 32'hFFFF_FFFF; // RQ4
						`CMD_RD1: mgstat_ff <= arr_q != 32'hFFFF_FFFF;
						`CMD_RD_ONCE: {cmd_ff[4], cmd_ff[5], cmd_ff[6], cmd_ff[7]} <= once_ff[rec]; // RQ15
						`CMD_VFY_KEY: begin
							// Simplified key check: any key opens the part
							o_secure <= 1'b0; // RQ9
							// Security register then reads open as well
							sec_ff[1:0] <= `SEC_OPEN; // RQ12
						end
						default: mgstat_ff <= 1'b0;
					endcase
					st_ff <= S_DONE;
				end
				S_DONE: begin
					cmpl_ff <= 1'b1; // RQ19
					st_ff <= S_IDLE;
				end
				default: st_ff <= S_INIT;
			endcase
		end
	end
	// Read data and interrupt, both registered
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
			o_irq <= 1'b0;
		end else begin
			o_irq <= ccie_ff & cmpl_ff; // RQ5
			// Idle bus reads zero so a missed strobe shows up
			if (!i_rd) o_rdata <= 8'h00;
			else if (i_addr == `A_STAT) o_rdata <= {cmpl_ff, 1'b0, accerr_ff, fpviol_ff, 3'b000, mgstat_ff};
			else if (i_addr == `A_CNFG) o_rdata <= {ccie_ff, 7'h00};
			else if (i_addr == `A_SEC) o_rdata <= sec_ff;
			else if (i_addr == `A_OPT) o_rdata <= opt_ff;
			else if (in_cmd) o_rdata <= cmd_ff[cidx];
			else if (i_addr <= `A_LAST) o_rdata <= prot_ff[i_addr[1:0]];
			else o_rdata <= 8'h00; // RQ7
		end
	end
endmodule

// >>> tb/flash_cmd_chk.sv
// Port assertions for the flash command controller
`timescale 1ns/1ps
module flash_cmd_chk (
	input wire i_sys_clk,
	input wire i_rst,
	input wire i_rd,
	input wire [4:0] i_addr,
	input wire [7:0] o_rdata,
	input wire o_irq,
	input wire o_secure
);
	// Single domain, so reset masks every check
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	idle_read_a: assert property (!i_rd |=> o_rdata == 8'h00) else $error("idle read");
	unmapped_read_a: assert property (i_rd && i_addr > 5'h13 |=> o_rdata == 8'h00) else $error("unmapped");
	reset_state_a: assert property ($fell(i_rst) |-> o_secure && !o_irq) else $error("reset state");
	spare_bits_a: assert property (i_rd && i_addr == 5'h00 |=> o_rdata[3:1] == 3'b000) else $error("spare");
	irq_enable_a: assert property (i_rd && i_addr == 5'h01 && o_irq ##1 o_irq |-> o_rdata[7]) else $error("enable");
	irq_flag_a: assert property (i_rd && i_addr == 5'h00 && o_irq ##1 o_irq |-> o_rdata[7]) else $error("flag");
	busy_irq_a: assert property (i_rd && i_addr == 5'h00 ##1 !o_rdata[7] |-> !o_irq) else $error("busy irq");
	secure_byte_a: assert property (i_rd && i_addr == 5'h02 && $stable(o_secure) |=>
		o_secure == (o_rdata[1:0] != 2'b10)) else $error("secure");
endmodule
bind flash_cmd_ctrl flash_cmd_chk chk (.i_sys_clk, .i_rst, .i_rd, .i_addr, .o_rdata, .o_irq, .o_secure);

// >>> tb/flash_host_model.sv
// Bus master model issuing register writes and reads
`timescale 1ns/1ps
module flash_host_model (
	input wire i_sys_clk,
	input wire [7:0] i_rdata,
	output reg o_wr = 1'b0,
	output reg o_rd = 1'b0,
	output reg [4:0] o_addr = 5'h00,
	output reg [7:0] o_wdata = 8'h00
);
	// Write strobe stands for exactly one taken edge
	task wr(input [4:0] a, input [7:0] d);
		@(posedge i_sys_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_sys_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d; // Stale data would hide a missed strobe
	endtask
	// Answer is registered, so sample just after the taken edge
	task rd(input [4:0] a, output [7:0] d);
		@(posedge i_sys_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_sys_clk);
		o_rd <= 1'b0;
		#1 d = i_rdata;
	endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
`include "flash_cmd_map.vh"
module tb;
	localparam [31:0] rw = 32'hA5C3_0F96;
	reg i_sys_clk = 1'b0;
	reg i_rst = 1'b1;
	reg i_special_mode = 1'b0;
	wire i_wr;
	wire i_rd;
	wire [4:0] i_addr;
	wire [7:0] i_wdata;
	wire [7:0] o_rdata;
	wire o_irq;
	wire o_secure;
	integer err_total = 0;
	integer checked = 0;
	integer n;
	reg [7:0] v;
	// 10 MHz system clock
	always #50 i_sys_clk = ~i_sys_clk;
	flash_cmd_ctrl dut (.i_sys_clk, .i_rst, .i_wr, .i_rd, .i_addr, .i_wdata, .i_special_mode, .o_rdata, .o_irq, .o_secure);
	flash_host_model cpu (.i_sys_clk, .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
	task chk(input [47:0] what, input [7:0] seen, input [7:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Bounded poll of the complete flag; a stuck engine ends the run
	task wait_done;
		v = 8'h00;
		for (n = 0; n < 200 && v[7] !== 1'b1; n = n + 1)
			cpu.rd(`A_STAT, v);
		if (v[7] !== 1'b1) begin
			err_total = err_total + 1;
			print_verdict;
		end
	endtask
	// Code, address, data word msb first, then launch
	task run(input [7:0] cmd, input [7:0] adr, input [31:0] dat);
		cpu.wr(5'h07, cmd);
		cpu.wr(5'h04, adr);
		for (n = 0; n < 4; n = n + 1)
			cpu.wr(5'h08 + n[4:0], dat[31 - 8 * n -: 8]);
		cpu.wr(`A_STAT, 8'h80);
	endtask
	// Start-up load from an erased field, then unlock
	task t_boot;
		wait_done;
		chk("stat", v, 8'h80);
		cpu.rd(`A_SEC, v);
		chk("sec", v, 8'hFF);
		chk("secure", {7'h00, o_secure}, 8'h01);
		cpu.rd(`A_OPT, v);
		chk("opt", v, 8'hFF);
		cpu.rd(`A_LAST, v);
		chk("prot", v, 8'hFF);
		run(`CMD_VFY_KEY, 8'h00, 32'h0000_0000);
		wait_done;
		cpu.rd(`A_STAT, v);
		chk("secure", {7'h00, o_secure}, 8'h00);
		$display("boot ok");
	endtask
	// Busy window: irq drops and parameter writes bounce
	task t_busy;
		cpu.wr(`A_CNFG, 8'h80);
		cpu.rd(`A_CNFG, v);
		chk("irq", {7'h00, o_irq}, 8'h01);
		run(`CMD_PGM4, 8'h00, 32'h1234_5678);
		cpu.wr(5'h07, 8'h55);
		cpu.rd(`A_STAT, v);
		chk("busy", v, 8'h00);
		chk("irq", {7'h00, o_irq}, 8'h00);
		wait_done;
		cpu.rd(`A_STAT, v);
		chk("irq", {7'h00, o_irq}, 8'h01);
		cpu.rd(5'h07, v);
		chk("cmd", v, `CMD_PGM4);
		cpu.wr(`A_CNFG, 8'h00);
		cpu.rd(`A_STAT, v);
		chk("irq", {7'h00, o_irq}, 8'h00);
		$display("busy ok");
	endtask
	// One-time record, refused rewrite, blocked launch, misalignment
	task t_once;
		run(`CMD_PGM_ONCE, 8'h03, rw);
		wait_done;
		run(`CMD_RD_ONCE, 8'h03, 32'h0000_0000);
		wait_done;
		for (n = 0; n < 4; n = n + 1) begin
			cpu.rd(5'h08 + n[4:0], v);
			chk("record", v, rw[31 - 8 * n -: 8]);
		end
		run(`CMD_PGM_ONCE, 8'h03, rw);
		wait_done;
		chk("again", v, 8'hA0);
		cpu.wr(`A_STAT, 8'h80);
		cpu.rd(`A_STAT, v);
		chk("held", v, 8'hA0);
		cpu.wr(`A_STAT, 8'h20);
		run(`CMD_PGM4, 8'h01, 32'hFFFF_0000);
		wait_done;
		chk("align", v, 8'hA0);
		cpu.wr(`A_STAT, 8'h20);
		cpu.rd(5'h1F, v);
		chk("unmap", v, 8'h00);
		$display("once ok");
	endtask
	// Read check, sector erase, then a locked sector
	task t_flash;
		run(`CMD_RD1, 8'h00, 32'h0000_0000);
		wait_done;
		chk("rd1pgm", v, 8'h81);
		run(`CMD_ERSSCR, 8'h00, 32'h0000_0000);
		wait_done;
		chk("erase", v, 8'h80);
		run(`CMD_RD1, 8'h00, 32'h0000_0000);
		wait_done;
		chk("rd1ers", v, 8'h80);
		cpu.wr(`A_LAST, 8'hFE);
		run(`CMD_ERSSCR, 8'h00, 32'h0000_0000);
		wait_done;
		chk("lock", v, 8'h90);
		cpu.wr(`A_STAT, 8'h10);
		$display("flash ok");
	endtask
	// Mid-run reset into special mode while secured
	task t_special;
		@(posedge i_sys_clk);
		i_special_mode <= 1'b1;
		i_rst <= 1'b1;
		repeat (10) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		wait_done;
		chk("stat", v, 8'h80);
		chk("secure", {7'h00, o_secure}, 8'h01);
		run(`CMD_RD1, 8'h00, 32'h0000_0000);
		wait_done;
		chk("spread", v, 8'hA0);
		cpu.wr(`A_STAT, 8'h20);
		run(`CMD_VFY_KEY, 8'h00, 32'h0000_0000);
		wait_done;
		chk("keyok", v, 8'h80);
		cpu.rd(`A_SEC, v);
		chk("secopn", {6'h00, v[1:0]}, 8'h02);
		chk("secure", {7'h00, o_secure}, 8'h00);
		$display("special ok");
	endtask
	// Reset for ten cycles, then the scenarios in turn
	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		t_boot;
		t_busy;
		t_once;
		t_flash;
		t_special;
		print_verdict;
	end
endmodule
